// file: design/ecf_regs.svh
// Purpose: register offsets, field positions and reset values of the event counter pair
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: definitions only
`ifndef ECF_REGS_SVH
`define ECF_REGS_SVH

`define ECF_ADDR_W 8
`define ECF_OFF_ESR_BASE 8'h00
`define ECF_OFF_CFG_BASE 8'h08
`define ECF_OFF_CNT_BASE 8'h10
`define ECF_STRIDE_WORD 8'h04
`define ECF_STRIDE_CNT 8'h08
`define ECF_OFF_CNT_HI 8'h04

`define ECF_CFG_OVF_BIT 31
`define ECF_MASK_LSB 9
`define ECF_CFG_WMASK 32'hC1FC_F000
`define ECF_ESR_WMASK 32'hFFFF_FE0C
`define ECF_CFG_RST 32'h0000_0000
`define ECF_ESR_RST 32'h0000_0000

`endif

// file: design/ecf_pkg.sv
// Purpose: shared types of the event counter pair
// Assumes: field layout matches the offsets and masks in ecf_regs.svh
// Notes: both register words are exactly 32 bits
`default_nettype none

package ecf_pkg;

  // event_select_reg: sub-event mask starts at absolute bit 9
  typedef struct packed {
    logic [6:0] evt_code;
    logic [15:0] mask;
    logic [4:0] rsv_hi;
    logic kernel_level_qualify;
    logic user_level_qualify;
    logic [1:0] rsv_lo;
  } ecf_esr_t;

  // counter_config_reg
  typedef struct packed {
    logic overflow_sticky_flag;
    logic cascade;
    logic [4:0] rsv_a;
    logic edge_det;
    logic [3:0] thr;
    logic cmpl;
    logic cmp;
    logic [1:0] rsv_b;
    logic [2:0] sel;
    logic en;
    logic [11:0] rsv_c;
  } ecf_cfg_t;

endpackage

`default_nettype wire

// file: design/ecf_counter_pair.sv
// Purpose: pair of filtered, cascadable performance-event counters behind an APB slave
// Assumes: event lines and user_mode synchronous to pclk; zero-wait APB answer
// Notes: counter k has counter 1-k as its cascade alternate
//
// Register access over APB and the register offsets were chosen for this implementation.
`include "ecf_regs.svh"
`default_nettype none

module ecf_counter_pair #(
  parameter int CNT_W = 40,
  parameter int N_ESR = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ECF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_ESR-1:0][3:0] ev_lines,
  input wire logic user_mode,
  input wire logic frd_req,
  input wire logic frd_idx,
  output logic [CNT_W-1:0] frd_data,
  output logic frd_valid,
  output logic [1:0] ovf_flags
);

  localparam int ESR_IW = (N_ESR > 1) ? $clog2(N_ESR) : 1;

  if (CNT_W < 33 || CNT_W > 64)
  begin : g_chk_w
    $error("CNT_W must be 33..64");
  end
  if (N_ESR < 2 || N_ESR > 8)
  begin : g_chk_esr
    $error("N_ESR must be 2..8");
  end

  typedef struct packed {
    ecf_pkg::ecf_esr_t [N_ESR-1:0] esr;
    ecf_pkg::ecf_cfg_t [1:0] cfg;
    logic [1:0][CNT_W-1:0] cnt;
    logic [1:0] prev_thr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [CNT_W-1:0] frd_data;
    logic frd_valid;
  } ecf_state_t;

  ecf_state_t st_ff;
  ecf_state_t nxt_st;

  logic setup;
  logic apb_wr;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [1:0][3:0] sel_val;
  logic [1:0] thr_hit;
  logic [1:0][3:0] inc;
  logic [1:0] run;
  logic [1:0] wrap;
  logic [1:0] wr_cnt;
  logic [1:0] wr_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [`ECF_ADDR_W-1:0] ecf_reg_addr(
    input logic [`ECF_ADDR_W-1:0] base,
    input logic [`ECF_ADDR_W-1:0] stride,
    input int idx
  );
    logic [`ECF_ADDR_W-1:0] a;
    a = base + `ECF_ADDR_W'(idx) * stride;
    return a;
  endfunction

  // event selection by sub-event mask, then privilege qualification
  function automatic logic [3:0] ecf_stage_val(
    input ecf_pkg::ecf_esr_t e,
    input logic [3:0] lines,
    input logic um
  );
    logic priv_ok;
    priv_ok = um ? e.user_level_qualify : e.kernel_level_qualify;
    return priv_ok ? (lines & e.mask[3:0]) : 4'h0;
  endfunction

  function automatic logic ecf_thr_hit(
    input ecf_pkg::ecf_cfg_t c,
    input logic [3:0] v
  );
    return c.cmpl ? (v <= c.thr) : (v > c.thr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [CNT_W:0] sum;
    logic [ESR_IW-1:0] eidx;
    logic [`ECF_ADDR_W-1:0] a_cnt;
    sum = '0;
    eidx = '0;
    a_cnt = '0;
    nxt_st = st_ff;
    setup = psel & ~penable;
    // pready only stands in the access cycle, so the write edge is unique
    apb_wr = psel & penable & pwrite & st_ff.pready & ~st_ff.pslverr;
    rd_hit = 1'b0;
    rd_val = 32'h0000_0000;
    wr_cnt = 2'b00;
    wr_cfg = 2'b00;

    // filter pipeline and counting
    for (int k = 0; k < 2; k++)
    begin
      sel_val[k] = 4'h0;
      eidx = st_ff.cfg[k].sel[ESR_IW-1:0];
      // selector is an index; out-of-range index selects nothing
      if (32'(st_ff.cfg[k].sel) < N_ESR)
      begin
        sel_val[k] = ecf_stage_val(st_ff.esr[eidx], ev_lines[eidx], user_mode);
      end
      thr_hit[k] = ecf_thr_hit(st_ff.cfg[k], sel_val[k]);
      if (!st_ff.cfg[k].cmp)
      begin
        inc[k] = sel_val[k];
      end
      else if (st_ff.cfg[k].edge_det)
      begin
        inc[k] = {3'h0, thr_hit[k] & ~st_ff.prev_thr[k]};
      end
      else
      begin
        inc[k] = {3'h0, thr_hit[k]};
      end
      nxt_st.prev_thr[k] = st_ff.cfg[k].cmp & thr_hit[k];
      run[k] = st_ff.cfg[k].en
        | (st_ff.cfg[k].cascade & st_ff.cfg[1-k].overflow_sticky_flag);
      sum = {1'b0, st_ff.cnt[k]} + (CNT_W+1)'(inc[k]);
      wrap[k] = run[k] & sum[CNT_W];
      if (run[k])
      begin
        nxt_st.cnt[k] = sum[CNT_W-1:0];
      end
    end

    // register decode: reads sampled in setup, writes at the access edge
    for (int k = 0; k < N_ESR; k++)
    begin
      if (paddr == ecf_reg_addr(`ECF_OFF_ESR_BASE, `ECF_STRIDE_WORD, k))
      begin
        rd_hit = 1'b1;
        rd_val = st_ff.esr[k];
        if (apb_wr)
        begin
          nxt_st.esr[k] = pwdata & `ECF_ESR_WMASK;
        end
      end
    end
    for (int k = 0; k < 2; k++)
    begin
      a_cnt = ecf_reg_addr(`ECF_OFF_CNT_BASE, `ECF_STRIDE_CNT, k);
      if (paddr == ecf_reg_addr(`ECF_OFF_CFG_BASE, `ECF_STRIDE_WORD, k))
      begin
        rd_hit = 1'b1;
        rd_val = st_ff.cfg[k];
        if (apb_wr)
        begin
          wr_cfg[k] = 1'b1;
          nxt_st.cfg[k] = pwdata & `ECF_CFG_WMASK;
        end
      end
      else if (paddr == a_cnt)
      begin
        rd_hit = 1'b1;
        rd_val = st_ff.cnt[k][31:0];
        if (apb_wr)
        begin
          wr_cnt[k] = 1'b1;
          nxt_st.cnt[k][31:0] = pwdata;
        end
      end
      else if (paddr == a_cnt + `ECF_OFF_CNT_HI)
      begin
        rd_hit = 1'b1;
        rd_val = 32'(st_ff.cnt[k] >> 32);
        if (apb_wr)
        begin
          wr_cnt[k] = 1'b1;
          nxt_st.cnt[k][CNT_W-1:32] = pwdata[CNT_W-33:0];
        end
      end
      // hardware set wins over a software clear in the same cycle
      if (wrap[k])
      begin
        nxt_st.cfg[k].overflow_sticky_flag = 1'b1;
      end
    end

    if (setup)
    begin
      nxt_st.prdata = rd_hit ? rd_val : 32'h0000_0000;
    end
    nxt_st.pready = setup;
    nxt_st.pslverr = setup & ~rd_hit;

    // fast read: index selects counter, answer one cycle later
    nxt_st.frd_valid = frd_req;
    if (frd_req)
    begin
      nxt_st.frd_data = st_ff.cnt[frd_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign frd_data = st_ff.frd_data;
  assign frd_valid = st_ff.frd_valid;
  assign ovf_flags = {st_ff.cfg[1].overflow_sticky_flag, st_ff.cfg[0].overflow_sticky_flag};

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_raw_add_value: assert property (
    run[0] && !st_ff.cfg[0].cmp && !wr_cnt[0]
    |=> st_ff.cnt[0] == CNT_W'($past(st_ff.cnt[0]) + CNT_W'($past(sel_val[0]))))
    else $error("raw input value not added");

  a_thr_adds_one: assert property (
    run[0] && st_ff.cfg[0].cmp && !st_ff.cfg[0].edge_det && !wr_cnt[0]
    |=> st_ff.cnt[0] == CNT_W'($past(st_ff.cnt[0]) + CNT_W'($past(thr_hit[0]))))
    else $error("threshold hit did not add exactly one");

  a_thr_sense: assert property (
    st_ff.cfg[0].cmp && sel_val[0] > st_ff.cfg[0].thr |-> thr_hit[0] != st_ff.cfg[0].cmpl)
    else $error("threshold comparison sense wrong");

  a_thr_sense_low: assert property (
    st_ff.cfg[0].cmp && sel_val[0] <= st_ff.cfg[0].thr |-> thr_hit[0] == st_ff.cfg[0].cmpl)
    else $error("threshold comparison sense wrong at or below threshold");

  a_sel_range: assert property (
    32'(st_ff.cfg[0].sel) >= N_ESR |-> sel_val[0] == 4'h0)
    else $error("out-of-range selector let events through");

  a_edge_no_level: assert property (
    run[0] && st_ff.cfg[0].cmp && st_ff.cfg[0].edge_det && thr_hit[0]
    ##1 run[0] && st_ff.cfg[0].cmp && st_ff.cfg[0].edge_det && thr_hit[0] && !wr_cnt[0]
    |=> $stable(st_ff.cnt[0]))
    else $error("edge mode counted a held level");

  a_edge_rise_counts: assert property (
    run[0] && st_ff.cfg[0].cmp && st_ff.cfg[0].edge_det && thr_hit[0] && !st_ff.prev_thr[0] && !wr_cnt[0]
    |=> st_ff.cnt[0] == CNT_W'($past(st_ff.cnt[0]) + 1'b1))
    else $error("edge mode missed a rising edge");

  a_edge_ignored: assert property (
    !st_ff.cfg[0].cmp |-> inc[0] == sel_val[0])
    else $error("edge flag acted without compare");

  a_stop_holds: assert property (
    !run[0] && !wr_cnt[0] |=> $stable(st_ff.cnt[0]))
    else $error("stopped counter changed");

  a_cascade_start: assert property (
    !st_ff.cfg[1].en && st_ff.cfg[1].cascade && st_ff.cfg[0].overflow_sticky_flag
    && inc[1] != 4'h0 && !wr_cnt[1] |=> st_ff.cnt[1] != $past(st_ff.cnt[1]))
    else $error("cascaded counter did not start");

  a_wrap_sets_ovf: assert property (
    run[0] && st_ff.cnt[0] == {CNT_W{1'b1}} && inc[0] == 4'h1 && !wr_cnt[0]
    |=> st_ff.cnt[0] == '0 && st_ff.cfg[0].overflow_sticky_flag)
    else $error("wrap did not reach zero with overflow");

  a_ovf_sticky: assert property (
    st_ff.cfg[0].overflow_sticky_flag && !wr_cfg[0] |=> st_ff.cfg[0].overflow_sticky_flag)
    else $error("overflow flag dropped without a write");

  a_fast_read: assert property (
    frd_req |=> frd_valid && frd_data == $past(st_ff.cnt[frd_idx]))
    else $error("fast read returned wrong count");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

  c_raw_count: cover property (run[0] && !st_ff.cfg[0].cmp && sel_val[0] == 4'hF);
  c_edge_hit: cover property (st_ff.cfg[0].cmp && st_ff.cfg[0].edge_det && inc[0] == 4'h1);
  c_cascade: cover property (!st_ff.cfg[1].en && run[1] && inc[1] != 4'h0);
  c_wrap: cover property (wrap[0]);

endmodule

`default_nettype wire

// file: testbench/ecf_event_src.sv
// Purpose: processor-side event line source for the counter pair
// Assumes: one pclk domain, values set by the bench
// Notes: alternates val_a and val_b each cycle; equal values give a steady level
`default_nettype none

module ecf_event_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] val_a,
  input wire logic [3:0] val_b,
  output logic [1:0][3:0] ev_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_ff <= 1'b0;
      ev_lines <= '0;
    end
    else
    begin
      ph_ff <= !ph_ff;
      ev_lines[0] <= ph_ff ? val_b : val_a;
      // second set differs so a wrong selector shows up
      ev_lines[1] <= ph_ff ? ~val_b : ~val_a;
    end
  end
endmodule

`default_nettype wire

// file: testbench/ecf_counter_pair_tb.sv
// Purpose: self-checking bench of the event counter pair
// Assumes: zero-wait APB slave, CNT_W of 40
// Notes: counts judged as the difference of two fast reads, so phase does not matter
`default_nettype none

module ecf_counter_pair_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // row: a, b, threshold, flags um/cmp/cmpl/edge, expected count over 8 edges
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] thr;
    logic um, cmp, cmpl, edg;
    logic [7:0] exp;
  } ecf_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic user_mode = 1'b1, frd_req = 1'b0, frd_idx = 1'b0, pready, pslverr, frd_valid;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] val_a = 4'h0, val_b = 4'h0;
  logic [1:0][3:0] ev_lines;
  logic [39:0] frd_data;
  logic [1:0] ovf_flags;
  int err_count = 0, total_checks = 0;
  ecf_row_t rows [11] = '{24'h9608_3C, 24'hFF08_78, 24'h7F6C_08, 24'h7F6E_00, 24'h676E_04, 24'h0FFC_00,
    24'h070E_04, 24'h776D_00, 24'h676D_04, 24'h3309_18, 24'hFF00_00};

  always #10 pclk = ~pclk;

  ecf_counter_pair #(.CNT_W(40), .N_ESR(2)) u_ecf_counter_pair (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ev_lines, .user_mode, .frd_req, .frd_idx, .frd_data,
    .frd_valid, .ovf_flags);
  ecf_event_src u_ecf_event_src (.pclk, .presetn, .val_a, .val_b, .ev_lines);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rv,
    output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    chk_val("pready", 64'h1, 64'(pready));
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic e;
    apb(1'b1, ad, wd, rd, e);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] ex);
    logic e;
    apb(1'b0, ad, 32'h0, rd, e);
    chk_val(nm, 64'(ex), 64'(rd));
  endtask

  // request held until the answer edge; each held cycle is a fresh request, harmless here
  task automatic fread(input logic ix, output logic [39:0] v);
    @(posedge pclk);
    frd_req <= 1'b1;
    frd_idx <= ix;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (frd_valid === 1'b1)
        break;
    end
    chk_val("frd_valid", 64'h1, 64'(frd_valid));
    v = frd_data;
    frd_req <= 1'b0;
  endtask

  // two fast reads eight edges apart
  task automatic span(input logic ix, input string nm, input logic [39:0] ex);
    logic [39:0] s, t;
    fread(ix, s);
    repeat (5) @(posedge pclk);
    fread(ix, t);
    chk_val(nm, 64'(ex), 64'(t - s));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic e;
    rdchk("cfg0", 8'h08, 32'h0);
    rdchk("cfg1", 8'h0C, 32'h0);
    rdchk("esr1", 8'h04, 32'h0);
    chk_val("ovf_flags", 64'h0, 64'(ovf_flags));
    apb(1'b0, 8'h40, 32'h0, rd, e);
    chk_val("unmapped_err", 64'h1, 64'(e));
  endtask

  task automatic t_filter;
    // user level only, mask bits 0..3 set, undocumented mask bits zero
    wr(8'h00, 32'h0C00_1E04);
    rdchk("esr0", 8'h00, 32'h0C00_1E04);
    foreach (rows[i])
    begin
      val_a <= rows[i].a;
      val_b <= rows[i].b;
      user_mode <= rows[i].um;
      // selector holds index 0, not an address
      wr(8'h08, {7'h0, rows[i].edg, rows[i].thr, rows[i].cmpl, rows[i].cmp, 5'h0, 1'b1, 12'h0});
      repeat (2) @(posedge pclk);
      span(1'b0, "cnt0_span", 40'(rows[i].exp));
    end
  endtask

  task automatic t_select;
    // kernel level only, mask bits 0..1: line 3 of the second set must be gated off
    val_a <= 4'h4;
    val_b <= 4'h4;
    user_mode <= 1'b0;
    wr(8'h04, 32'h0000_0608);
    rdchk("esr1_prog", 8'h04, 32'h0000_0608);
    wr(8'h08, 32'h0000_3000);
    repeat (2) @(posedge pclk);
    span(1'b0, "cnt0_sel1", 40'h18);
    // selector index past the last select register counts nothing
    wr(8'h08, 32'h0000_5000);
    repeat (2) @(posedge pclk);
    span(1'b0, "cnt0_sel_none", 40'h0);
  endtask

  task automatic t_cascade;
    logic [39:0] v;
    val_a <= 4'hF;
    val_b <= 4'hF;
    user_mode <= 1'b1;
    wr(8'h08, 32'h0);
    wr(8'h10, 32'hFFFF_FFF0);
    wr(8'h14, 32'h0000_00FF);
    rdchk("cnt0_hi", 8'h14, 32'h0000_00FF);
    wr(8'h0C, 32'h4000_0000);
    wr(8'h08, 32'h0000_1000);
    for (int i = 0; i < 40 && ovf_flags[0] !== 1'b1; i++)
      @(posedge pclk);
    chk_val("ovf0_set", 64'h1, 64'(ovf_flags[0]));
    fread(1'b0, v);
    chk_val("cnt0_wrapped", 64'h1, 64'(v < 40'h100));
    span(1'b1, "cnt1_cascade", 40'h78);
    repeat (8) @(posedge pclk);
    rdchk("cfg0_ovf", 8'h08, 32'h8000_1000);
    wr(8'h08, 32'h0);
    #1;
    chk_val("ovf0_cleared", 64'h0, 64'(ovf_flags[0]));
    span(1'b1, "cnt1_halted", 40'h0);
    span(1'b0, "cnt0_halted", 40'h0);
    fread(1'b0, v);
    rdchk("cnt0_lo", 8'h10, v[31:0]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_filter();
    t_select();
    t_cascade();
    results();
  end

  // whole run is near 330 cycles; the 20000-cycle limit, some sixty times that, means a hang
  initial
  begin
    #400000;
    err_count++;
    results();
  end
endmodule

`default_nettype wire
